// File: src/tw_cfg.svh
// Offsets, reset values, command codes and timing counts of the register slave
`ifndef TW_CFG_SVH
`define TW_CFG_SVH

`define TW_SLV_ADDR_RST  7'h7A
`define TW_OFF_CMD       16'h0000
`define TW_OFF_SEQ_STATE 16'h0002
`define TW_OFF_SLV_ADDR  16'h0004
`define TW_OFF_BYTE_WIN  16'h0006
`define TW_OFF_CFG       16'h0010
`define TW_CFG_RST       16'h0000
`define TW_CMD_STREAM    16'h0001
`define TW_CMD_STOP      16'h0002
`define TW_CMD_TEST      16'h0003
`define TW_CMD_IDLE      16'h0004
`define TW_CMD_LAT       4
`define TW_ADDR_STEP     16'h0002

`endif

// File: src/tw_pkg.sv
// Types shared by the register slave and its sequencer
`default_nettype none
package tw_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RX,
        ST_ACK,
        ST_TX,
        ST_RACK,
        ST_IGNORE
    } tw_state_t;

    typedef enum logic [1:0] {
        PH_DEV,
        PH_AHI,
        PH_ALO,
        PH_DAT
    } tw_phase_t;

    typedef enum logic [1:0] {
        SEQ_STOPPED,
        SEQ_STREAM,
        SEQ_TEST,
        SEQ_IDLE
    } tw_seq_t;

endpackage : tw_pkg

`default_nettype wire

// File: src/two_wire_sequencer.sv
// Command sequencer: executes host commands and reports completion
`timescale 1ns/1ns
`default_nettype none
`include "tw_cfg.svh"

module two_wire_sequencer
    import tw_pkg::*;
#(
    parameter int CMD_LAT = `TW_CMD_LAT
)(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic [15:0] cmd,
    output tw_seq_t          seq_state,
    output logic             seq_done
);

    localparam int CNT_W = 8;

    logic             busy_q;
    logic [15:0]      cmd_q;
    logic [CNT_W-1:0] cnt_q;

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            seq_state <= SEQ_STOPPED;
            seq_done  <= 1'b0;
            busy_q    <= 1'b0;
            cmd_q     <= 16'h0000;
            cnt_q     <= '0;
        end
        else if (ce)
        begin
            seq_done <= 1'b0;
            if (!busy_q && !seq_done && cmd != 16'h0000)
            begin
                busy_q <= 1'b1;
                cmd_q  <= cmd;
                cnt_q  <= CNT_W'(CMD_LAT - 1);
            end
            else if (busy_q)
            begin
                if (cnt_q == '0)
                begin
                    busy_q   <= 1'b0;
                    seq_done <= 1'b1;
                    case (cmd_q)
                        `TW_CMD_STREAM: seq_state <= SEQ_STREAM;
                        `TW_CMD_STOP:   seq_state <= SEQ_STOPPED;
                        `TW_CMD_TEST:   seq_state <= SEQ_TEST;
                        `TW_CMD_IDLE:   seq_state <= SEQ_IDLE;
                        default:        seq_state <= seq_state;
                    endcase
                end
                else
                begin
                    cnt_q <= cnt_q - CNT_W'(1);
                end
            end
        end
    end

    AST_SEQ_DONE_AFTER_COUNT: assert property (
        @(posedge core_clk) disable iff (rst || !ce)
        (busy_q && cnt_q == '0) |=> (seq_done && !busy_q))
        else $error("command not completed when its count ran out");

    AST_SEQ_DONE_PULSE: assert property (
        @(posedge core_clk) disable iff (rst || !ce)
        seq_done |=> !seq_done)
        else $error("completion pulse longer than one cycle");

endmodule : two_wire_sequencer

`default_nettype wire

// File: src/two_wire_register_slave.sv
// Two-wire serial register slave with 16-bit addresses and data words
`timescale 1ns/1ns
`default_nettype none
`include "tw_cfg.svh"

// Operation
// - Device is slave only; never drives the clock or starts a transfer.
// - Data falling while clock high is a start.
// - Data rising while clock high is a stop; engine returns idle.
// - A start without prior stop restarts the transfer.
// - Bytes are eight bits, MSB first, one bit per clock period.
// - Data line changes only while clock low.
// - First byte holds seven address bits and a direction bit, one reads.
// - Slave address comes out of reset at its default value.
// - Register addresses are two bytes, high byte first.
// - Data moves as 16-bit words; single bytes only via the byte window.
// - Receiver pulls data low in the ninth period to acknowledge.
// - Address byte acknowledged only when it matches the programmed address.
// - Write: two address bytes then two data bytes, each acknowledged.
// - Read: address written first, then restart and read byte, data returned.
// - Master acks bytes it wants continued and nacks the last.
// - Read without address phase uses the address kept from before.
// - Sequential read keeps supplying bytes while the master acknowledges.
// - Sequential write accepts further data bytes until a stop.
// - Host writes a command; device clears it to zero when executed.
// - Configuration is applied only while the sequencer is stopped.
// - Idle or test-pattern state suspends automatic updates.
module two_wire_register_slave
    import tw_pkg::*;
#(
    parameter int REG_WORDS = 32,
    parameter int CMD_LAT   = `TW_CMD_LAT
)(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        serial_clk,
    input  wire logic        serial_data_line_i,
    output logic             serial_data_line_o,
    output logic             serial_data_line_oe,
    input  wire logic        deep_sleep_input,
    output tw_seq_t          seq_state,
    output logic             auto_alg_en,
    output logic [15:0]      active_cfg
);

    localparam int IW      = $clog2(REG_WORDS);
    localparam int CMD_IDX = `TW_OFF_CMD / 2;
    localparam int CFG_IDX = `TW_OFF_CFG / 2;

    function automatic logic reg_hit(input logic [15:0] a);
        reg_hit = (a[15:IW+1] == '0) && !a[0];
    endfunction : reg_hit

    function automatic logic [IW-1:0] reg_idx(input logic [15:0] a);
        reg_idx = a[IW:1];
    endfunction : reg_idx

    // Link side: sample the data line on the serial clock
    logic link_bit_q;

    always_ff @(posedge serial_clk)
    begin
        link_bit_q <= serial_data_line_i;
    end

    // Core side synchronisers
    logic scl_s1_q;
    logic scl_s2_q;
    logic scl_d_q;
    logic sda_s1_q;
    logic sda_s2_q;
    logic sda_d_q;
    logic slp_s1_q;
    logic slp_s2_q;

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            scl_s1_q <= 1'b1;
            scl_s2_q <= 1'b1;
            scl_d_q  <= 1'b1;
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
            sda_d_q  <= 1'b1;
            slp_s1_q <= 1'b0;
            slp_s2_q <= 1'b0;
        end
        else if (ce)
        begin
            scl_s1_q <= serial_clk;
            scl_s2_q <= scl_s1_q;
            scl_d_q  <= scl_s2_q;
            sda_s1_q <= serial_data_line_i;
            sda_s2_q <= sda_s1_q;
            sda_d_q  <= sda_s2_q;
            slp_s1_q <= deep_sleep_input;
            slp_s2_q <= slp_s1_q;
        end
    end

    logic start_det;
    logic stop_det;
    logic rise;
    logic fall;

    assign start_det = scl_s2_q & scl_d_q & sda_d_q & ~sda_s2_q;
    assign stop_det  = scl_s2_q & scl_d_q & ~sda_d_q & sda_s2_q;
    assign rise      = scl_s2_q & ~scl_d_q;
    assign fall      = ~scl_s2_q & scl_d_q;

    // Engine state
    tw_state_t   state_q;
    tw_phase_t   phase_q;
    tw_phase_t   next_phase;
    logic [3:0]  bit_cnt_q;
    logic [7:0]  shreg_q;
    logic [7:0]  tx_q;
    logic        sda_oe_q;
    logic        rw_q;
    logic        more_q;
    logic        rd_lo_q;
    logic [6:0]  slv_addr_q;
    logic [15:0] addr_q;
    logic [7:0]  wr_hi_q;
    logic        wr_half_q;
    logic [15:0] regs_q [REG_WORDS];
    logic [15:0] rd_word;
    logic [7:0]  tx_byte;
    logic        byte_ack;
    logic        win_hit;
    logic        quiet;
    logic        rx_done;
    logic        wr_commit;
    logic        rd_adv;
    logic        seq_done;
    logic [15:0] wr_word;

    assign quiet     = ~start_det & ~stop_det;
    assign win_hit   = (addr_q == `TW_OFF_BYTE_WIN);
    assign rx_done   = quiet & (state_q == ST_RX) & fall & (bit_cnt_q == 4'h8);
    assign wr_commit = ce & rx_done & (phase_q == PH_DAT) & (win_hit | wr_half_q);
    assign rd_adv    = ce & quiet & (state_q == ST_TX) & fall & (bit_cnt_q == 4'h8)
                       & rd_lo_q & ~win_hit;
    assign wr_word   = win_hit ? {8'h00, shreg_q} : {wr_hi_q, shreg_q};

    // Address byte must match; later bytes of a write are always taken
    assign byte_ack = (phase_q != PH_DEV)
                      || ((shreg_q[7:1] == slv_addr_q) && !slp_s2_q);

    always_comb
    begin
        case (phase_q)
            PH_DEV:  next_phase = PH_AHI;
            PH_AHI:  next_phase = PH_ALO;
            default: next_phase = PH_DAT;
        endcase
    end

    always_comb
    begin
        rd_word = 16'h0000;
        if (!reg_hit(addr_q))
            rd_word = 16'h0000;
        else if (addr_q == `TW_OFF_SEQ_STATE)
            rd_word = {14'h0000, seq_state};
        else if (addr_q == `TW_OFF_SLV_ADDR)
            rd_word = {9'h000, slv_addr_q};
        else
            rd_word = regs_q[reg_idx(addr_q)];
    end

    // High byte first, low byte second; window gives one byte
    assign tx_byte = (win_hit || rd_lo_q) ? rd_word[7:0] : rd_word[15:8];

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            state_q   <= ST_IDLE;
            phase_q   <= PH_DEV;
            bit_cnt_q <= 4'h0;
            shreg_q   <= 8'h00;
            tx_q      <= 8'h00;
            sda_oe_q  <= 1'b0;
            rw_q      <= 1'b0;
            more_q    <= 1'b0;
            rd_lo_q   <= 1'b0;
        end
        else if (ce)
        begin
            if (start_det)
            begin
                state_q   <= ST_RX;
                phase_q   <= PH_DEV;
                bit_cnt_q <= 4'h0;
                sda_oe_q  <= 1'b0;
            end
            else if (stop_det)
            begin
                state_q  <= ST_IDLE;
                sda_oe_q <= 1'b0;
            end
            else
            begin
                case (state_q)
                    ST_RX:
                    begin
                        if (rise && bit_cnt_q != 4'h8)
                        begin
                            shreg_q   <= {shreg_q[6:0], link_bit_q};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end
                        else if (fall && bit_cnt_q == 4'h8)
                        begin
                            bit_cnt_q <= 4'h0;
                            if (byte_ack)
                            begin
                                state_q  <= ST_ACK;
                                sda_oe_q <= 1'b1;
                            end
                            else
                            begin
                                state_q <= ST_IGNORE;
                            end
                            if (phase_q == PH_DEV)
                            begin
                                rw_q    <= shreg_q[0];
                                rd_lo_q <= 1'b0;
                            end
                        end
                    end
                    ST_ACK:
                    begin
                        if (fall)
                        begin
                            phase_q <= next_phase;
                            if (rw_q)
                            begin
                                state_q  <= ST_TX;
                                tx_q     <= tx_byte;
                                sda_oe_q <= ~tx_byte[7];
                            end
                            else
                            begin
                                state_q  <= ST_RX;
                                sda_oe_q <= 1'b0;
                            end
                        end
                    end
                    ST_TX:
                    begin
                        if (rise)
                        begin
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end
                        else if (fall && bit_cnt_q == 4'h8)
                        begin
                            state_q   <= ST_RACK;
                            sda_oe_q  <= 1'b0;
                            bit_cnt_q <= 4'h0;
                            rd_lo_q   <= ~rd_lo_q;
                        end
                        else if (fall)
                        begin
                            tx_q     <= {tx_q[6:0], 1'b0};
                            sda_oe_q <= ~tx_q[6];
                        end
                    end
                    ST_RACK:
                    begin
                        if (rise)
                        begin
                            more_q <= ~link_bit_q;
                        end
                        else if (fall && more_q)
                        begin
                            state_q  <= ST_TX;
                            tx_q     <= tx_byte;
                            sda_oe_q <= ~tx_byte[7];
                        end
                        else if (fall)
                        begin
                            state_q <= ST_IGNORE;
                        end
                    end
                    default:
                    begin
                        sda_oe_q <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Internal address and write assembly
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            addr_q    <= 16'h0000;
            wr_hi_q   <= 8'h00;
            wr_half_q <= 1'b0;
        end
        else if (ce)
        begin
            if (start_det)
            begin
                wr_half_q <= 1'b0;
            end
            else if (rx_done && phase_q == PH_AHI)
            begin
                addr_q[15:8] <= shreg_q;
            end
            else if (rx_done && phase_q == PH_ALO)
            begin
                addr_q[7:0] <= shreg_q;
                wr_half_q   <= 1'b0;
            end
            else if (wr_commit)
            begin
                wr_half_q <= 1'b0;
                if (!win_hit)
                    addr_q <= addr_q + `TW_ADDR_STEP;
            end
            else if (rx_done && phase_q == PH_DAT)
            begin
                wr_hi_q   <= shreg_q;
                wr_half_q <= 1'b1;
            end
            else if (rd_adv)
            begin
                addr_q <= addr_q + `TW_ADDR_STEP;
            end
        end
    end

    // Register store; a host write in the clearing cycle wins
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < REG_WORDS; i++)
                regs_q[i] <= 16'h0000;
        end
        else if (ce)
        begin
            if (seq_done)
                regs_q[CMD_IDX] <= 16'h0000;
            if (wr_commit && reg_hit(addr_q))
                regs_q[reg_idx(addr_q)] <= wr_word;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            slv_addr_q <= `TW_SLV_ADDR_RST;
        else if (ce && wr_commit && addr_q == `TW_OFF_SLV_ADDR)
            slv_addr_q <= shreg_q[6:0];
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            active_cfg  <= `TW_CFG_RST;
            auto_alg_en <= 1'b0;
        end
        else if (ce)
        begin
            if (seq_state == SEQ_STOPPED)
                active_cfg <= regs_q[CFG_IDX];
            auto_alg_en <= (seq_state == SEQ_STREAM) || (seq_state == SEQ_STOPPED);
        end
    end

    two_wire_sequencer #(
        .CMD_LAT (CMD_LAT)
    ) u_seq (
        .core_clk  (core_clk),
        .rst       (rst),
        .ce        (ce),
        .cmd       (regs_q[CMD_IDX]),
        .seq_state (seq_state),
        .seq_done  (seq_done)
    );

    // Open drain: only ever pulls low, clock pin is input only
    assign serial_data_line_o  = 1'b0;
    assign serial_data_line_oe = sda_oe_q;

    AST_DRIVE_ONLY_WHEN_OWED: assert property (
        @(posedge core_clk) disable iff (rst || !ce)
        sda_oe_q |-> (state_q == ST_ACK || state_q == ST_TX))
        else $error("data line driven outside acknowledge or transmit");

    AST_START_RESTARTS: assert property (
        @(posedge core_clk) disable iff (rst || !ce)
        start_det |=> (state_q == ST_RX && phase_q == PH_DEV && bit_cnt_q == 4'h0))
        else $error("start not taken as new transfer");

    AST_STOP_RELEASES: assert property (
        @(posedge core_clk) disable iff (rst || !ce)
        stop_det |=> (state_q == ST_IDLE && !sda_oe_q))
        else $error("stop did not release the bus");

    AST_REPEATED_START: assert property (
        @(posedge core_clk) disable iff (rst || !ce)
        (start_det && state_q != ST_IDLE) |=> (phase_q == PH_DEV && !sda_oe_q))
        else $error("repeated start not accepted");

    AST_BIT_COUNT: assert property (
        @(posedge core_clk) disable iff (rst || !ce)
        (state_q == ST_RX && bit_cnt_q == 4'h8) |-> !(rise && quiet) ##1 bit_cnt_q <= 4'h8)
        else $error("more than eight bits in a byte");

    AST_CHANGE_ON_LOW: assert property (
        @(posedge core_clk) disable iff (rst || !ce)
        ($changed(sda_oe_q) && !$past(start_det) && !$past(stop_det)) |-> !$past(scl_s2_q))
        else $error("data line changed while clock high");

    AST_DEFAULT_ADDR: assert property (
        @(posedge core_clk) disable iff (rst)
        $past(rst) |-> (slv_addr_q == `TW_SLV_ADDR_RST))
        else $error("slave address not at default after reset");

    AST_ACK_DRIVES_LOW: assert property (
        @(posedge core_clk) disable iff (rst || !ce)
        $rose(state_q == ST_ACK) |-> (sda_oe_q && $past(fall)))
        else $error("acknowledge not driven low after byte");

    AST_ADDR_MATCH: assert property (
        @(posedge core_clk) disable iff (rst || !ce)
        (state_q == ST_ACK && $past(state_q) == ST_RX && $past(phase_q) == PH_DEV)
        |-> ($past(shreg_q[7:1]) == $past(slv_addr_q) && !$past(slp_s2_q)))
        else $error("address byte acknowledged without match");

    AST_WORD_ADVANCE: assert property (
        @(posedge core_clk) disable iff (rst || !ce)
        (wr_commit && !win_hit) |=> (addr_q == $past(addr_q) + `TW_ADDR_STEP))
        else $error("address did not advance after a word");

    AST_CMD_CLEARED: assert property (
        @(posedge core_clk) disable iff (rst || !ce)
        (seq_done && !(wr_commit && addr_q == `TW_OFF_CMD)) |=> (regs_q[CMD_IDX] == 16'h0000))
        else $error("command not cleared after execution");

    AST_CFG_ONLY_STOPPED: assert property (
        @(posedge core_clk) disable iff (rst || !ce)
        $changed(active_cfg) |-> ($past(seq_state) == SEQ_STOPPED))
        else $error("configuration applied outside stopped state");

    AST_AUTO_SUSPENDED: assert property (
        @(posedge core_clk) disable iff (rst || !ce)
        (seq_state == SEQ_IDLE || seq_state == SEQ_TEST) |=> !auto_alg_en)
        else $error("automatic updates running in idle or test");

endmodule : two_wire_register_slave

`default_nettype wire

// File: bench/host_master.sv
// Two-wire bus master model: makes the serial clock and drives the data line
`timescale 1ns/1ns
`default_nettype none
module host_master (
    output logic      serial_clk,
    output logic      sda_rel,
    input  wire logic sda_wire
);
    logic tick;

    initial
    begin
        tick = 1'b0;
        serial_clk = 1'b1;
        sda_rel = 1'b1;
        forever
        begin
            #7 tick = 1'b1;
            #8 tick = 1'b0;
        end
    end

    task automatic step(input int n);
        repeat (n) @(posedge tick);
    endtask : step

    // Also serves as repeated start with no stop before it
    task automatic start();
        sda_rel = 1'b1;
        step(2);
        serial_clk = 1'b1;
        step(3);
        sda_rel = 1'b0;
        step(3);
        serial_clk = 1'b0;
        step(1);
    endtask : start

    // Clock stays high afterwards: bus idle
    task automatic stop();
        sda_rel = 1'b0;
        step(2);
        serial_clk = 1'b1;
        step(3);
        sda_rel = 1'b1;
        step(3);
    endtask : stop

    task automatic bit_io(input logic b, output logic r);
        sda_rel = b;
        step(2);
        serial_clk = 1'b1;
        step(3);
        r = sda_wire;
        serial_clk = 1'b0;
        step(2);
    endtask : bit_io

    // Eight bits then the acknowledge period; mack high releases the line
    task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
                        output logic ack);
        for (int i = 7; i >= 0; i--)
            bit_io(tx[i], rx[i]);
        bit_io(mack, ack);
        ack = ~ack;
    endtask : xfer
endmodule : host_master
`default_nettype wire

// File: bench/tb.sv
// Self-checking bench of the two-wire register slave
`timescale 1ns/1ns
`default_nettype none
`include "tw_cfg.svh"
module tb;
    import tw_pkg::*;
    logic        core_clk;
    logic        rst;
    logic        ce;
    logic        deep_sleep_input;
    logic        serial_clk;
    logic        sda_rel;
    logic        serial_data_line_o;
    logic        serial_data_line_oe;
    tw_seq_t     seq_state;
    logic        auto_alg_en;
    logic [15:0] active_cfg;
    logic [6:0]  dev;
    int          n_fail;
    int          tests_run;
    // Last code is undefined: cleared, state kept
    logic [15:0] cmds [5] = '{`TW_CMD_STREAM, `TW_CMD_TEST, `TW_CMD_IDLE, `TW_CMD_STOP, 16'h0007};
    tw_seq_t     sts  [5] = '{SEQ_STREAM, SEQ_TEST, SEQ_IDLE, SEQ_STOPPED, SEQ_STOPPED};
    logic        algs [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
    wire logic   sda_w = sda_rel & ~(serial_data_line_oe & ~serial_data_line_o);

    two_wire_register_slave #(.REG_WORDS(32), .CMD_LAT(`TW_CMD_LAT)) two_wire_register_slave_inst (
        .core_clk(core_clk), .rst(rst), .ce(ce), .serial_clk(serial_clk),
        .serial_data_line_i(sda_w), .serial_data_line_o(serial_data_line_o),
        .serial_data_line_oe(serial_data_line_oe), .deep_sleep_input(deep_sleep_input),
        .seq_state(seq_state), .auto_alg_en(auto_alg_en), .active_cfg(active_cfg));
    host_master host_master_inst (.serial_clk(serial_clk), .sda_rel(sda_rel), .sda_wire(sda_w));

    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : finish_test

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic put(input logic [7:0] b, input logic exp_ack);
        logic [7:0] rx;
        logic       a;
        host_master_inst.xfer(b, 1'b1, rx, a);
        chk({15'h0, a}, {15'h0, exp_ack});
    endtask : put

    task automatic probe(input logic [6:0] d, input logic exp_ack);
        host_master_inst.start();
        put({d, 1'b0}, exp_ack);
        host_master_inst.stop();
    endtask : probe

    task automatic wr(input logic [15:0] adr, input logic [15:0] d0, input logic [15:0] d1,
                      input int n);
        host_master_inst.start();
        put({dev, 1'b0}, 1'b1);
        put(adr[15:8], 1'b1);
        put(adr[7:0], 1'b1);
        if (n > 0)
        begin
            put(d0[15:8], 1'b1);
            put(d0[7:0], 1'b1);
        end
        if (n > 1)
        begin
            put(d1[15:8], 1'b1);
            put(d1[7:0], 1'b1);
        end
        host_master_inst.stop();
    endtask : wr

    task automatic rd(input logic set_adr, input logic [15:0] adr, input logic [15:0] e0,
                      input logic [15:0] e1, input int n);
        logic [15:0] w;
        logic        a;
        if (set_adr)
        begin
            host_master_inst.start();
            put({dev, 1'b0}, 1'b1);
            put(adr[15:8], 1'b1);
            put(adr[7:0], 1'b1);
        end
        host_master_inst.start();
        put({dev, 1'b1}, 1'b1);
        for (int k = 0; k < n; k++)
        begin
            host_master_inst.xfer(8'hFF, 1'b0, w[15:8], a);
            host_master_inst.xfer(8'hFF, k == n - 1, w[7:0], a);
            chk(w, (k == 0) ? e0 : e1);
        end
        host_master_inst.stop();
    endtask : rd

    task automatic cmd_walk();
        for (int i = 0; i < 5; i++)
        begin
            wr(`TW_OFF_CMD, cmds[i], 16'h0000, 1);
            repeat (`TW_CMD_LAT + 4) @(negedge core_clk);
            chk({14'h0, seq_state}, {14'h0, sts[i]});
            chk({15'h0, auto_alg_en}, {15'h0, algs[i]});
            rd(1'b1, `TW_OFF_CMD, 16'h0000, {14'h0, sts[i]}, 2);
            if (i == 0)
            begin
                wr(`TW_OFF_CFG, 16'h5A5A, 16'h0000, 1);
                chk(active_cfg, 16'hABCD);
            end
        end
        repeat (4) @(negedge core_clk);
        chk(active_cfg, 16'h5A5A);
    endtask : cmd_walk

    initial
    begin
        #300000;
        n_fail++;
        finish_test();
    end

    initial
    begin
        n_fail = 0;
        tests_run = 0;
        rst = 1'b1;
        ce = 1'b1;
        deep_sleep_input = 1'b0;
        dev = 7'h7A;
        repeat (8) @(negedge core_clk);
        rst = 1'b0;
        repeat (4) @(negedge core_clk);
        chk({14'h0, seq_state}, {14'h0, SEQ_STOPPED});
        probe(7'h7A, 1'b1);
        probe(7'h3C, 1'b0);
        @(negedge core_clk);
        deep_sleep_input = 1'b1;
        repeat (4) @(negedge core_clk);
        probe(7'h7A, 1'b0);
        @(negedge core_clk);
        deep_sleep_input = 1'b0;
        repeat (4) @(negedge core_clk);
        wr(`TW_OFF_CFG, 16'hABCD, 16'h1234, 2);
        chk(active_cfg, 16'hABCD);
        rd(1'b1, `TW_OFF_CFG, 16'hABCD, 16'h1234, 2);
        wr(16'h0012, 16'h0000, 16'h0000, 0);
        rd(1'b0, 16'h0000, 16'h1234, 16'h0000, 1);
        cmd_walk();
        wr(`TW_OFF_SLV_ADDR, 16'h0078, 16'h0000, 1);
        dev = 7'h78;
        probe(7'h7A, 1'b0);
        probe(7'h78, 1'b1);
        wr(`TW_OFF_BYTE_WIN, 16'h5AC3, 16'h0000, 1);
        rd(1'b1, `TW_OFF_SLV_ADDR, 16'h0078, 16'hC3C3, 2);
        finish_test();
    end
endmodule : tb
`default_nettype wire
